// >>> src/fclc_pkg.sv
// configuration register one, latency lookup and command codes of the flash
// assumes one core clock domain and a serial link clock that runs only in frames
// Behaviour
// - latency code picks dummy cycles; mode cycles follow the read kind
// - sdr enhanced latency table per code
// - ddr enhanced latency table per code
// - protect_from_bottom picks protection start end
// - one-time bits never clear, failure flags error except on bits frozen by lock
// - volatile protect bits load 111 on reset
// - ships with protect bits and volatility cleared
// - param_sectors_on_top places small sector block
// - uniform sectors make param placement ignored
// - protection start and param block independent
// - four lanes turn protect/pause pins into data
// - quad commands need four_lane_enable set
// - lock refuses protect, bottom and placement writes, not the volatility bit
// - unlocked bits, lock included, stay writable
// - lock clears only on power or hardware reset
// - one register write may also set lock

package fclc_pkg;

    // ************************************************************
    // command codes seen on the serial link
    // ************************************************************
    localparam logic [7:0] CMD_WRITE_REGS = 8'h01;
    localparam logic [7:0] CMD_READ_STATUS = 8'h05;
    localparam logic [7:0] CMD_READ_CONFIG = 8'h35;
    localparam logic [7:0] CMD_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] CMD_WRITE_DISABLE = 8'h04;
    localparam logic [7:0] CMD_CLEAR_STATUS = 8'h30;
    localparam logic [7:0] CMD_SOFT_RESET = 8'hF0;

    // ************************************************************
    // frame lengths in link clock edges
    // ************************************************************
    localparam logic [4:0] FRAME_CMD_BITS = 5'h08;
    localparam logic [4:0] FRAME_SR_BITS = 5'h10;
    localparam logic [4:0] FRAME_CR_BITS = 5'h18;
    localparam logic [4:0] CMD_LAST_IDX = 5'h07;
    localparam logic [4:0] SR_LAST_IDX = 5'h0F;
    localparam logic [4:0] CR_LAST_IDX = 5'h17;

    // ************************************************************
    // field positions of status_reg_one and reset values
    // ************************************************************
    localparam int SR_PERR_BIT = 6;
    localparam int SR_BP_HI = 4;
    localparam int SR_BP_LO = 2;
    localparam int SR_WEL_BIT = 1;
    localparam logic [7:0] CFG_SHIP_VALUE = 8'h00;
    localparam logic [2:0] BP_SHIP_VALUE = 3'h0;
    localparam logic [2:0] BP_VOLATILE_LOAD = 3'h7;
    localparam logic [3:0] LEARN_MIN_DUMMY = 4'h5;

    // config_reg_one layout, msb first
    typedef struct packed {
        logic [1:0] latency_code;
        logic protect_from_bottom;
        logic reserved;
        logic protect_bits_volatile;
        logic param_sectors_on_top;
        logic four_lane_enable;
        logic protection_lock;
    } fclc_config_s;

    typedef struct packed {
        logic [2:0] mode;
        logic [3:0] dummy;
    } fclc_latency_s;

    typedef enum logic [3:0] {
        RK_READ = 4'h0,
        RK_FAST = 4'h1,
        RK_DUAL_OUT = 4'h2,
        RK_QUAD_OUT = 4'h3,
        RK_DUAL_IO = 4'h4,
        RK_QUAD_IO = 4'h5,
        RK_DDR_FAST = 4'h6,
        RK_DDR_DUAL = 4'h7,
        RK_DDR_QUAD = 4'h8
    } fclc_read_kind_e;

    typedef enum logic [3:0] {
        PH_IDLE = 4'h1,
        PH_MODE = 4'h2,
        PH_DUMMY = 4'h4,
        PH_DATA = 4'h8
    } fclc_phase_e;

    // mode and dummy cycles per read kind and code (00, 01, 10, 11)
    function automatic fclc_latency_s fclc_latency(input logic [3:0] kind,
                                                   input logic [1:0] code);
        fclc_latency_s lat;
        lat = '0;
        case (kind)
            RK_FAST, RK_DUAL_OUT, RK_QUAD_OUT: lat.dummy = (code == 2'h3) ? 4'h0 : 4'h8;
            RK_DUAL_IO: begin
                lat.mode = 3'h4;
                lat.dummy = (code == 2'h1) ? 4'h1 : (code == 2'h2) ? 4'h2 : 4'h0;
            end
            RK_QUAD_IO: begin
                lat.mode = 3'h2;
                lat.dummy = (code == 2'h3) ? 4'h1 : (code == 2'h2) ? 4'h5 : 4'h4;
            end
            RK_DDR_FAST: begin
                lat.mode = 3'h4;
                lat.dummy = (code == 2'h0) ? 4'h2 : (code == 2'h1) ? 4'h4 :
                            (code == 2'h2) ? 4'h5 : 4'h1;
            end
            RK_DDR_DUAL: begin
                lat.mode = 3'h2;
                lat.dummy = (code == 2'h0) ? 4'h4 : (code == 2'h1) ? 4'h5 :
                            (code == 2'h2) ? 4'h6 : 4'h2;
            end
            RK_DDR_QUAD: begin
                lat.mode = 3'h1;
                lat.dummy = (code == 2'h0) ? 4'h6 : (code == 2'h1) ? 4'h7 :
                            (code == 2'h2) ? 4'h8 : 4'h3;
            end
            default: lat = '0;
        endcase
        return lat;
    endfunction : fclc_latency

endpackage : fclc_pkg

// >>> src/fclc_sync.sv
// two flip-flop synchroniser for levels entering a clock domain
// assumes the input is quasi-static or a level; reset is synchronous
`timescale 1ns/1ns

module fclc_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);

    logic [WIDTH-1:0] meta;

    // first stage feeds only the second
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            meta <= INIT;
            q_o <= INIT;
        end else begin
            meta <= d_i;
            q_o <= meta;
        end
    end

endmodule : fclc_sync

// >>> src/fclc_top.sv
// configuration register one with protection bits and read latency sequencing
// assumes the serial link clock runs only while chip select is low
`timescale 1ns/1ns

module fclc_top (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic hw_reset_n_i,
    input wire logic sck_i,
    input wire logic cs_n_i,
    input wire logic si_i,
    output logic so_o,
    output logic so_oe_o,
    input wire logic write_protect_pin_n_i,
    input wire logic pause_pin_n_i,
    input wire logic uniform_sectors_i,
    input wire logic read_start_i,
    input wire logic [3:0] read_kind_i,
    input wire logic read_end_i,
    output fclc_pkg::fclc_config_s config_o,
    output logic [2:0] block_protect_level_o,
    output logic program_error_flag_o,
    output logic write_enable_latch_o,
    output logic param_top_o,
    output logic write_protect_n_eff_o,
    output logic pause_n_eff_o,
    output logic otp_write_ok_o,
    output fclc_pkg::fclc_latency_s latency_o,
    output fclc_pkg::fclc_phase_e phase_o,
    output logic data_start_o,
    output logic read_refused_o,
    output logic learning_ok_o
);
    import fclc_pkg::*;

    // ************************************************************
    // link side, clocked by the serial clock
    // ************************************************************
    logic fresh;
    logic [4:0] bit_cnt;
    logic [6:0] shift;
    logic [7:0] cmd_byte;
    logic [7:0] sr_byte;
    logic [7:0] cr_byte;
    logic [7:0] out_sr;
    logic [15:0] regs_link;
    logic [15:0] regs_core;

    // position of the bit on this edge; first edge of a frame is zero
    wire [4:0] bit_idx = fresh ? 5'h00 : bit_cnt;
    wire [7:0] byte_now = {shift, si_i};
    wire bit_saturated = (bit_idx == FRAME_CR_BITS);
    wire [4:0] next_bit_cnt = bit_saturated ? bit_idx : 5'(bit_idx + 5'h01);
    wire cmd_reads_sr = (byte_now == CMD_READ_STATUS);
    wire cmd_reads_cr = (byte_now == CMD_READ_CONFIG);
    wire [7:0] read_byte = cmd_reads_sr ? regs_link[15:8] : regs_link[7:0];

    // chip select high marks the next edge as the first of a frame
    always_ff @(posedge sck_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            fresh <= 1'b1;
        end else begin
            fresh <= 1'b0;
        end
    end

    // bit count and captured bytes hold still after the frame
    always_ff @(posedge sck_i) begin
        bit_cnt <= next_bit_cnt;
        shift <= byte_now[6:0];
        if (bit_idx == CMD_LAST_IDX) cmd_byte <= byte_now;
        if (bit_idx == SR_LAST_IDX) sr_byte <= byte_now;
        if (bit_idx == CR_LAST_IDX) cr_byte <= byte_now;
    end

    // register read-out shifter, released when the frame ends
    always_ff @(posedge sck_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            out_sr <= 8'h00;
            so_oe_o <= 1'b0;
            so_o <= 1'b0;
        end else if (bit_idx == CMD_LAST_IDX && (cmd_reads_sr || cmd_reads_cr)) begin
            out_sr <= {read_byte[6:0], 1'b0};
            so_oe_o <= 1'b1;
            so_o <= read_byte[7];
        end else begin
            out_sr <= {out_sr[6:0], 1'b0};
            so_o <= out_sr[7];
        end
    end

    // register image, changed only between frames, brought into the link domain
    fclc_sync #(.WIDTH(16), .INIT(16'h0000)) u_regs_to_link (
        .clk_i(sck_i),
        .reset_i(1'b0),
        .d_i(regs_core),
        .q_o(regs_link)
    );

    // ************************************************************
    // pin synchronisers into the core domain
    // ************************************************************
    logic cs_n_s;
    logic cs_n_prev;
    logic hw_reset_n_s;
    logic [1:0] lane_pins_s;

    fclc_sync #(.WIDTH(1), .INIT(1'h1)) u_cs_sync (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .d_i(cs_n_i),
        .q_o(cs_n_s)
    );

    fclc_sync #(.WIDTH(1), .INIT(1'h1)) u_hw_reset_sync (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .d_i(hw_reset_n_i),
        .q_o(hw_reset_n_s)
    );

    fclc_sync #(.WIDTH(2), .INIT(2'h3)) u_lane_sync (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .d_i({write_protect_pin_n_i, pause_pin_n_i}),
        .q_o(lane_pins_s)
    );

    // edge detector on the synchronised chip select
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            cs_n_prev <= 1'b1;
        end else begin
            cs_n_prev <= cs_n_s;
        end
    end

    // ************************************************************
    // frame decode; link bytes are stable once chip select is high
    // ************************************************************
    fclc_config_s cfg_q;
    fclc_config_s cfg_wr;
    fclc_config_s next_cfg;
    logic [2:0] bp_q;
    logic [2:0] next_bp;
    logic perr_q;
    logic next_perr;
    logic wel_q;
    logic next_wel;

    wire frame_end = cs_n_s & ~cs_n_prev;
    wire cmd_frame = frame_end && (bit_cnt == FRAME_CMD_BITS);
    wire hw_rst = ~hw_reset_n_s;
    wire soft_rst = cmd_frame && (cmd_byte == CMD_SOFT_RESET);
    wire any_rst = hw_rst | soft_rst;
    wire wr_len_ok = (bit_cnt == FRAME_SR_BITS) || (bit_cnt == FRAME_CR_BITS);
    wire wr_ok = frame_end && (cmd_byte == CMD_WRITE_REGS) && wel_q && wr_len_ok;
    wire wr_cfg = wr_ok && (bit_cnt == FRAME_CR_BITS);
    wire locked = cfg_q.protection_lock;
    assign cfg_wr = fclc_config_s'(cr_byte);

    // attempt to return a set one-time bit to zero; frozen bits are just refused
    wire clear_try_bottom = cfg_q.protect_from_bottom & ~cfg_wr.protect_from_bottom & ~locked;
    wire clear_try_top = cfg_q.param_sectors_on_top & ~cfg_wr.param_sectors_on_top & ~locked;
    wire clear_try_vol = cfg_q.protect_bits_volatile & ~cfg_wr.protect_bits_volatile;
    wire otp_fail = wr_cfg && (clear_try_bottom | clear_try_top | clear_try_vol);

    // next configuration value
    always_comb begin
        next_cfg = cfg_q;
        next_cfg.reserved = 1'b0;
        if (wr_cfg) begin
            next_cfg.latency_code = cfg_wr.latency_code;
            next_cfg.four_lane_enable = cfg_wr.four_lane_enable;
            // one-time bits only ever go from zero to one, each on its own
            next_cfg.protect_bits_volatile = cfg_q.protect_bits_volatile
                | cfg_wr.protect_bits_volatile;
            if (!locked) begin
                next_cfg.protect_from_bottom = cfg_q.protect_from_bottom
                    | cfg_wr.protect_from_bottom;
                next_cfg.param_sectors_on_top = cfg_q.param_sectors_on_top
                    | cfg_wr.param_sectors_on_top;
            end
            next_cfg.protection_lock = cfg_q.protection_lock
                | cfg_wr.protection_lock;
        end
        if (hw_rst) begin
            next_cfg.protection_lock = 1'b0;
        end
    end

    // protect level, error flag and write enable latch
    always_comb begin
        next_bp = bp_q;
        if (any_rst && cfg_q.protect_bits_volatile) begin
            next_bp = BP_VOLATILE_LOAD;
        end else if (wr_ok && !locked) begin
            next_bp = sr_byte[SR_BP_HI:SR_BP_LO];
        end
        next_perr = perr_q;
        if ((cmd_frame && cmd_byte == CMD_CLEAR_STATUS) || any_rst) begin
            next_perr = 1'b0;
        end
        if (otp_fail) begin
            next_perr = 1'b1;
        end
        next_wel = wel_q;
        if (cmd_frame && cmd_byte == CMD_WRITE_ENABLE) begin
            next_wel = 1'b1;
        end
        if ((cmd_frame && cmd_byte == CMD_WRITE_DISABLE) || wr_ok || any_rst) begin
            next_wel = 1'b0;
        end
    end

    // register state; power-on reset gives the shipped values
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            cfg_q <= fclc_config_s'(CFG_SHIP_VALUE);
            bp_q <= BP_SHIP_VALUE;
            perr_q <= 1'b0;
            wel_q <= 1'b0;
        end else begin
            cfg_q <= next_cfg;
            bp_q <= next_bp;
            perr_q <= next_perr;
            wel_q <= next_wel;
        end
    end

    // image handed to the link for reads
    assign regs_core = {1'b0, perr_q, 1'b0, bp_q, wel_q, 1'b0, cfg_q};

    // ************************************************************
    // read latency sequencer
    // ************************************************************
    fclc_phase_e phase_q;
    fclc_phase_e next_phase;
    fclc_latency_s lat_q;
    logic [3:0] cyc_q;
    logic [3:0] next_cyc;

    wire kind_quad = (read_kind_i == RK_QUAD_OUT) || (read_kind_i == RK_QUAD_IO)
        || (read_kind_i == RK_DDR_QUAD);
    wire start_idle = read_start_i && (phase_q == PH_IDLE);
    wire refuse = start_idle && kind_quad && !cfg_q.four_lane_enable;
    wire accept = start_idle && !refuse;
    fclc_latency_s lat_new;
    assign lat_new = fclc_latency(read_kind_i, cfg_q.latency_code);

    // mode cycles first, then dummies, then data
    always_comb begin
        next_phase = phase_q;
        next_cyc = cyc_q;
        unique case (phase_q)
            PH_IDLE: begin
                if (accept) begin
                    if (lat_new.mode != 3'h0) begin
                        next_phase = PH_MODE;
                        next_cyc = 4'({1'b0, lat_new.mode} - 4'h1);
                    end else if (lat_new.dummy != 4'h0) begin
                        next_phase = PH_DUMMY;
                        next_cyc = 4'(lat_new.dummy - 4'h1);
                    end else begin
                        next_phase = PH_DATA;
                    end
                end
            end
            PH_MODE: begin
                if (cyc_q != 4'h0) begin
                    next_cyc = 4'(cyc_q - 4'h1);
                end else if (lat_q.dummy != 4'h0) begin
                    next_phase = PH_DUMMY;
                    next_cyc = 4'(lat_q.dummy - 4'h1);
                end else begin
                    next_phase = PH_DATA;
                end
            end
            PH_DUMMY: begin
                if (cyc_q != 4'h0) begin
                    next_cyc = 4'(cyc_q - 4'h1);
                end else begin
                    next_phase = PH_DATA;
                end
            end
            PH_DATA: begin
                if (read_end_i) next_phase = PH_IDLE;
            end
        endcase
        if (any_rst) next_phase = PH_IDLE;
    end

    // sequencer state and latency capture
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            phase_q <= PH_IDLE;
            cyc_q <= 4'h0;
            lat_q <= '0;
        end else begin
            phase_q <= next_phase;
            cyc_q <= next_cyc;
            if (accept) lat_q <= lat_new;
        end
    end

    // ************************************************************
    // registered outputs
    // ************************************************************
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            write_protect_n_eff_o <= 1'b1;
            pause_n_eff_o <= 1'b1;
            param_top_o <= 1'b0;
            otp_write_ok_o <= 1'b1;
            data_start_o <= 1'b0;
            read_refused_o <= 1'b0;
            learning_ok_o <= 1'b0;
        end else begin
            // lanes two and three carry data, their pin roles read inactive
            write_protect_n_eff_o <= cfg_q.four_lane_enable | lane_pins_s[1];
            pause_n_eff_o <= cfg_q.four_lane_enable | lane_pins_s[0];
            param_top_o <= cfg_q.param_sectors_on_top & ~uniform_sectors_i;
            otp_write_ok_o <= ~cfg_q.protection_lock;
            data_start_o <= (next_phase == PH_DATA) && (phase_q != PH_DATA);
            read_refused_o <= refuse;
            learning_ok_o <= (lat_q.dummy >= LEARN_MIN_DUMMY);
        end
    end

    assign config_o = cfg_q;
    assign block_protect_level_o = bp_q;
    assign program_error_flag_o = perr_q;
    assign write_enable_latch_o = wel_q;
    assign latency_o = lat_q;
    assign phase_o = phase_q;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    a_lock_holds: assert property (cfg_q.protection_lock && !hw_rst |=> cfg_q.protection_lock)
        else $error("lock cleared without hardware reset");
    a_otp_never_falls: assert property (!$fell(cfg_q.protect_from_bottom)
        && !$fell(cfg_q.param_sectors_on_top) && !$fell(cfg_q.protect_bits_volatile))
        else $error("one-time bit returned to zero");
    a_otp_error_set: assert property (otp_fail |=> perr_q ##1 (perr_q || any_rst))
        else $error("failed one-time clear did not flag error");
    a_frozen_level: assert property (locked && !any_rst |=> $stable(bp_q))
        else $error("protect level changed while locked");
    a_volatile_load: assert property (hw_rst && cfg_q.protect_bits_volatile
        |=> bp_q == BP_VOLATILE_LOAD)
        else $error("volatile protect level not loaded on reset");
    a_quad_refused: assert property (start_idle && kind_quad && !cfg_q.four_lane_enable
        |=> read_refused_o && phase_q == PH_IDLE)
        else $error("quad read started without four lanes");
    a_mode_first: assert property (accept && lat_new.mode != 3'h0 && !any_rst
        |=> phase_q == PH_MODE)
        else $error("mode cycles not first");
    a_data_reached: assert property (accept && !any_rst |-> ##[1:14] data_start_o)
        else $error("data phase not reached in time");
    a_lanes_inactive: assert property (cfg_q.four_lane_enable
        |=> write_protect_n_eff_o && pause_n_eff_o)
        else $error("pin roles active in four lane mode");
    a_uniform_param: assert property (uniform_sectors_i |=> !param_top_o)
        else $error("param placement active with uniform sectors");

endmodule : fclc_top

// >>> verification/fclc_host_model.sv
// host-side serial controller model that sends command frames to the flash
// assumes the device samples si on the rising link clock; the clock idles low
`timescale 1ns/1ns

module fclc_host_model (
    input logic so_i,
    input logic oe_i,
    output logic sck_o,
    output logic cs_n_o,
    output logic si_o
);
    // ****************************************
    // idle levels and frame sender
    // ****************************************
    initial begin
        sck_o = 1'b0;
        si_o = 1'b1;
        // raised after time zero so the device surely sees the edge that arms its frame start
        #1 cs_n_o = 1'b1;
    end

    // sends n bits msb first from d[23]; link clock runs only inside the frame
    // the bench runs its read latency checks before it sets any one-time bits
    // q keeps the last eight bits seen on so just before each rising edge; x while not driven
    task automatic frame(input logic [23:0] d, input int n, output logic [7:0] q);
        q = 8'h00;
        #3 cs_n_o = 1'b0;
        for (int i = 0; i < n; i++) begin
            si_o = d[23 - i];
            #6 q = {q[6:0], oe_i ? so_i : 1'bx};
            #1 sck_o = 1'b1;
            #8 sck_o = 1'b0;
        end
        #7 cs_n_o = 1'b1;
        si_o = ~si_o; // released line shows no stale value
    endtask : frame
endmodule : fclc_host_model

// >>> verification/fclc_top_tb.sv
// self-checking bench for configuration register one and read latency sequencing
// assumes the host model drives the link; all other inputs come from here
`timescale 1ns/1ns

module flash_config_latency_ctrl_tb;
    import fclc_pkg::*;
    // ****************************************
    // clock, reset, design and host model
    // ****************************************
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic hw_reset_n_i = 1'b1;
    logic wp_n = 1'b1;
    logic uniform = 1'b0;
    logic rd_start = 1'b0;
    logic rd_end = 1'b0;
    logic [3:0] rd_kind = 4'h0;
    logic sck, cs_n, si, refused, dstart, learn, wp_eff, ptop, perr, otp_ok;
    logic so, so_oe, wel, ps_eff;
    logic [7:0] rv;
    fclc_config_s cfg;
    fclc_latency_s lat;
    fclc_phase_e ph;
    logic [2:0] bp;
    int n_fail = 0;
    int samples_checked = 0;
    int cycles = 0;
    // dummies per read kind, nibbles for codes 00,01,10,11
    logic [15:0] dum_tab [9] = '{16'h0000, 16'h8880, 16'h8880, 16'h8880, 16'h0120,
                                 16'h4451, 16'h2451, 16'h4562, 16'h6783};
    logic [2:0] mode_tab [9] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h4, 3'h2, 3'h4, 3'h2, 3'h1};

    always #20 clk_i = ~clk_i;

    fclc_host_model host (.so_i(so), .oe_i(so_oe), .sck_o(sck), .cs_n_o(cs_n), .si_o(si));

    fclc_top dut (.clk_i(clk_i), .reset_i(reset_i), .hw_reset_n_i(hw_reset_n_i),
        .sck_i(sck), .cs_n_i(cs_n), .si_i(si), .so_o(so), .so_oe_o(so_oe),
        .write_protect_pin_n_i(wp_n), .pause_pin_n_i(wp_n), .uniform_sectors_i(uniform),
        .read_start_i(rd_start), .read_kind_i(rd_kind), .read_end_i(rd_end),
        .config_o(cfg), .block_protect_level_o(bp), .program_error_flag_o(perr),
        .write_enable_latch_o(wel), .param_top_o(ptop), .write_protect_n_eff_o(wp_eff),
        .pause_n_eff_o(ps_eff), .otp_write_ok_o(otp_ok), .latency_o(lat), .phase_o(ph),
        .data_start_o(dstart), .read_refused_o(refused), .learning_ok_o(learn));

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic ticks(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : ticks

    task automatic cmd(input logic [7:0] c);
        host.frame({c, 16'h0000}, 8, rv);
        ticks(8);
    endtask : cmd

    // register read frame: command byte, then eight bits shifted out by the device
    task automatic rd_reg(input logic [7:0] c, output logic [7:0] v);
        host.frame({c, 16'h0000}, 16, v);
        ticks(8);
    endtask : rd_reg

    task automatic wr_cfg(input logic [2:0] lvl, input logic [7:0] cr);
        cmd(CMD_WRITE_ENABLE);
        chk("wel_set", 8'h01, {7'h0, wel});
        host.frame({CMD_WRITE_REGS, 3'h0, lvl, 2'h0, cr}, 24, rv);
        ticks(8);
        chk("wel_clear", 8'h00, {7'h0, wel});
    endtask : wr_cfg

    task automatic start_read(input logic [3:0] k);
        rd_kind = k;
        rd_start = 1'b1;
        ticks(1);
        rd_start = 1'b0;
    endtask : start_read

    task automatic report_and_stop;
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : report_and_stop

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_quad_refused;
        wp_n = 1'b0;
        ticks(6);
        chk("wp_eff", 8'h00, {7'h0, wp_eff});
        chk("ps_eff", 8'h00, {7'h0, ps_eff});
        start_read(RK_QUAD_IO);
        chk("refused", 8'h01, {7'h0, refused});
        chk("phase", PH_IDLE, {4'h0, ph});
    endtask : t_quad_refused

    task automatic t_latency;
        int n;
        logic [3:0] d;
        for (int c = 0; c < 4; c++) begin
            wr_cfg(3'h0, {c[1:0], 6'h02});
            chk("wp_forced", 8'h01, {7'h0, wp_eff});
            chk("ps_forced", 8'h01, {7'h0, ps_eff});
            for (int k = 0; k < 9; k++) begin
                d = dum_tab[k][15 - 4 * c -: 4];
                start_read(k[3:0]);
                n = 1;
                while (dstart !== 1'b1 && n < 40) begin
                    ticks(1);
                    n++;
                end
                chk("latency", {1'b0, mode_tab[k], d}, {1'b0, lat});
                chk("data_cycle", 8'(1 + mode_tab[k] + d), 8'(n));
                chk("phase_data", PH_DATA, {4'h0, ph});
                rd_end = 1'b1;
                ticks(1);
                rd_end = 1'b0;
                // advice flag follows the captured latency one cycle later
                chk("learn", {7'h0, d >= 4'h5}, {7'h0, learn});
                ticks(1);
            end
        end
    endtask : t_latency

    task automatic t_otp;
        wr_cfg(3'h0, 8'h24);
        chk("cfg", 8'h24, cfg);
        chk("ptop", 8'h01, {7'h0, ptop});
        uniform = 1'b1;
        ticks(3);
        chk("ptop_uniform", 8'h00, {7'h0, ptop});
        uniform = 1'b0;
        wr_cfg(3'h0, 8'h00);
        chk("cfg_kept", 8'h24, cfg);
        chk("perr", 8'h01, {7'h0, perr});
        rd_reg(CMD_READ_STATUS, rv);
        chk("status_read", 8'h40, rv);
        rd_reg(CMD_READ_CONFIG, rv);
        chk("config_read", 8'h24, rv);
        cmd(CMD_CLEAR_STATUS);
        chk("perr_clear", 8'h00, {7'h0, perr});
    endtask : t_otp

    task automatic t_lock;
        wr_cfg(3'h3, 8'h2D);
        chk("cfg_lock", 8'h2D, cfg);
        chk("otp_ok", 8'h00, {7'h0, otp_ok});
        wr_cfg(3'h5, 8'h2C);
        chk("bp_frozen", 8'h03, {5'h0, bp});
        cmd(CMD_SOFT_RESET);
        chk("lock_soft", 8'h2D, cfg);
        chk("bp_soft", 8'h07, {5'h0, bp});
        rd_reg(CMD_READ_STATUS, rv);
        chk("status_soft", 8'h1C, rv);
        hw_reset_n_i = 1'b0;
        ticks(4);
        hw_reset_n_i = 1'b1;
        ticks(8);
        chk("lock_hw", 8'h2C, cfg);
        chk("bp_hw", 8'h07, {5'h0, bp});
    endtask : t_lock

    // ****************************************
    // main sequence and hang guard
    // ****************************************
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            report_and_stop();
        end
    end

    initial begin
        ticks(10);
        reset_i = 1'b0;
        ticks(5);
        chk("cfg_reset", 8'h00, cfg);
        chk("bp_reset", 8'h00, {5'h0, bp});
        t_quad_refused();
        t_latency();
        t_otp();
        t_lock();
        report_and_stop();
    end
endmodule : flash_config_latency_ctrl_tb
